//--- include/usr_pkg.sv
// shared constants for the universal shift/storage register
package usr_pkg;

  // storage width and synchroniser depth
  localparam int unsigned WIDTH = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // positions inside the synchronised pin bundle
  localparam int unsigned IN_CLK = 0;
  localparam int unsigned IN_RSI = 1;
  localparam int unsigned IN_LSI = 2;
  localparam int unsigned IN_SEL_LO = 3;
  localparam int unsigned IN_SEL_HI = 4;
  localparam int unsigned IN_CLR_N = 5;
  localparam int unsigned IN_OEA_N = 6;
  localparam int unsigned IN_OEB_N = 7;
  localparam int unsigned IN_PINS = 8;
  localparam int unsigned IN_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STEP = 8'h08;

  // control register fields
  localparam int unsigned CTRL_OVR = 0;
  localparam int unsigned CTRL_SEL_LO = 1;
  localparam int unsigned CTRL_SEL_HI = 2;
  localparam int unsigned CTRL_CLEAR = 3;
  localparam int unsigned CTRL_HIZ = 4;
  localparam int unsigned CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // status register fields
  localparam int unsigned ST_STORE = 0;
  localparam int unsigned ST_MODE = 8;
  localparam int unsigned ST_DRV = 10;
  localparam int unsigned ST_Q0 = 11;
  localparam int unsigned ST_Q7 = 12;

  // step register field and reset values
  localparam int unsigned STEP_GO = 0;
  localparam logic [7:0] STORE_RST = 8'h00;

  // operating modes, in select order {high bit, low bit}
  typedef enum logic [1:0] {
    USR_HOLD,
    USR_SHIFT_RIGHT,
    USR_SHIFT_LEFT,
    USR_LOAD
  } usr_mode_t;

endpackage : usr_pkg

//--- hw/usr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser bank for pin inputs
module usr_sync #(
  parameter int unsigned W = 16
) (
  // clock
  input wire logic i_clk,
  // raw pins and synchronised copies
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  // the first stage feeds only the second stage
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk) begin
      meta_r[g] <= i_d[g];
      o_q[g] <= meta_r[g];
    end
  end

endmodule : usr_sync

`default_nettype wire

//--- hw/usr_shift_reg.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - eight storage flip-flops, bit 0 to 7
// - selects pick hold, right, left, load
// - low clear at edge zeroes all bits
// - contents change only at a rising pin clock edge or a software step write
// - load mode captures parallel pins
// - shift right: serial in to bit 0
// - shift left: serial in to bit 7
// - hold mode keeps all bits
// - enabled drivers put bits on pins
// - either enable high floats all pins
// - operations continue with drivers disabled
// - both selects high floats pins for load
// - bit 0 and 7 always on serial outs
module usr_shift_reg (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // control pins
  input wire logic i_shift_clock,
  input wire logic i_right_serial_in,
  input wire logic i_left_serial_in,
  input wire logic i_mode_select_low_bit,
  input wire logic i_mode_select_high_bit,
  input wire logic i_sync_clear_n,
  input wire logic i_pin_drive_enable_a_n,
  input wire logic i_pin_drive_enable_b_n,
  // parallel pins, split three ways
  input wire logic [7:0] i_parallel_pins,
  output logic [7:0] o_parallel_pins,
  output logic [7:0] o_parallel_pins_oe,
  // serial outputs for cascading
  output logic o_bit_zero_serial_out,
  output logic o_bit_seven_serial_out
);

  logic [usr_pkg::IN_W-1:0] raw_w;
  logic [usr_pkg::IN_W-1:0] sync_w;
  logic clk_s;
  logic rsi_s;
  logic lsi_s;
  logic sel_lo_s;
  logic sel_hi_s;
  logic clr_n_s;
  logic oea_n_s;
  logic oeb_n_s;
  logic [7:0] pins_s;
  logic clk_prev_r;
  logic pin_edge_w;
  logic [usr_pkg::CTRL_W-1:0] ctrl_r;
  logic acc_w;
  logic done_w;
  logic wr_w;
  logic hit_ctrl_w;
  logic hit_status_w;
  logic hit_step_w;
  logic hit_any_w;
  logic sw_step_w;
  logic step_w;
  logic ovr_w;
  logic [1:0] sel_w;
  usr_pkg::usr_mode_t mode_w;
  logic clr_n_w;
  logic drv_nxt;
  logic [7:0] store_r;
  logic [7:0] store_nxt;
  logic [31:0] status_w;
  logic [31:0] rd_mux_w;

  // pins come from outside the clock domain, so all pass two flops
  assign raw_w = {i_parallel_pins, i_pin_drive_enable_b_n, i_pin_drive_enable_a_n,
                  i_sync_clear_n, i_mode_select_high_bit, i_mode_select_low_bit,
                  i_left_serial_in, i_right_serial_in, i_shift_clock};

  usr_sync #(
    .W(usr_pkg::IN_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_d(raw_w),
    .o_q(sync_w)
  );

  // named views of the synchronised bundle
  assign clk_s = sync_w[usr_pkg::IN_CLK];
  assign rsi_s = sync_w[usr_pkg::IN_RSI];
  assign lsi_s = sync_w[usr_pkg::IN_LSI];
  assign sel_lo_s = sync_w[usr_pkg::IN_SEL_LO];
  assign sel_hi_s = sync_w[usr_pkg::IN_SEL_HI];
  assign clr_n_s = sync_w[usr_pkg::IN_CLR_N];
  assign oea_n_s = sync_w[usr_pkg::IN_OEA_N];
  assign oeb_n_s = sync_w[usr_pkg::IN_OEB_N];
  assign pins_s = sync_w[usr_pkg::IN_PINS +: 8];

  // remember the synchronised shift clock for edge detection
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= clk_s;
    end
  end

  // apb decode; one wait state gives time to register read data
  assign acc_w = i_psel & i_penable;
  assign done_w = acc_w & o_pready;
  assign wr_w = done_w & i_pwrite;
  assign hit_ctrl_w = (i_paddr == usr_pkg::OFS_CTRL);
  assign hit_status_w = (i_paddr == usr_pkg::OFS_STATUS);
  assign hit_step_w = (i_paddr == usr_pkg::OFS_STEP);
  assign hit_any_w = hit_ctrl_w | hit_status_w | hit_step_w;

  // a step is a rising pin clock edge or a software step write
  assign pin_edge_w = clk_s & ~clk_prev_r;
  assign sw_step_w = wr_w & hit_step_w & i_pwdata[usr_pkg::STEP_GO];
  assign step_w = pin_edge_w | sw_step_w;

  // software may take over the selects from the pins and add a clear to the pin clear
  assign ovr_w = ctrl_r[usr_pkg::CTRL_OVR];
  assign sel_w = ovr_w ? {ctrl_r[usr_pkg::CTRL_SEL_HI], ctrl_r[usr_pkg::CTRL_SEL_LO]}
                       : {sel_hi_s, sel_lo_s};
  assign mode_w = usr_pkg::usr_mode_t'(sel_w);
  assign clr_n_w = clr_n_s & ~(ovr_w & ctrl_r[usr_pkg::CTRL_CLEAR]);

  // next contents; clear wins over every mode
  always_comb begin
    store_nxt = store_r;
    if (step_w) begin
      if (!clr_n_w) begin
        store_nxt = usr_pkg::STORE_RST;
      end else begin
        case (mode_w)
          usr_pkg::USR_HOLD: begin
            store_nxt = store_r;
          end
          usr_pkg::USR_SHIFT_RIGHT: begin
            store_nxt = {store_r[6:0], rsi_s};
          end
          usr_pkg::USR_SHIFT_LEFT: begin
            store_nxt = {lsi_s, store_r[7:1]};
          end
          usr_pkg::USR_LOAD: begin
            store_nxt = pins_s;
          end
          default: begin
            store_nxt = store_r;
          end
        endcase
      end
    end
  end

  // drivers on only with both enables low and no load pending
  assign drv_nxt = ~oea_n_s & ~oeb_n_s & (mode_w != usr_pkg::USR_LOAD)
                   & ~ctrl_r[usr_pkg::CTRL_HIZ];

  // the eight storage flops; enables do not gate them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      store_r <= usr_pkg::STORE_RST;
    end else begin
      store_r <= store_nxt;
    end
  end

  // pin values and serial outputs come straight from storage
  assign o_parallel_pins = store_r;
  assign o_bit_zero_serial_out = store_r[0];
  assign o_bit_seven_serial_out = store_r[7];

  // driver enable flops, one per pin position
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_parallel_pins_oe <= 8'h00;
    end else begin
      o_parallel_pins_oe <= {8{drv_nxt}};
    end
  end

  // control register, written at the completing access edge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= usr_pkg::CTRL_RST;
    end else if (wr_w && hit_ctrl_w) begin
      ctrl_r <= i_pwdata[usr_pkg::CTRL_W-1:0];
    end
  end

  // status view of the block's own state
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[usr_pkg::ST_STORE +: 8] = store_r;
    status_w[usr_pkg::ST_MODE +: 2] = sel_w;
    status_w[usr_pkg::ST_DRV] = o_parallel_pins_oe[0];
    status_w[usr_pkg::ST_Q0] = store_r[0];
    status_w[usr_pkg::ST_Q7] = store_r[7];
  end

  // read mux; the step register reads as zero
  assign rd_mux_w = hit_ctrl_w ? {{(32 - usr_pkg::CTRL_W){1'b0}}, ctrl_r}
                  : hit_status_w ? status_w : 32'h0000_0000;

  // answer one cycle into the access phase; unmapped gets an error
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc_w & ~o_pready;
      o_prdata <= (acc_w && !o_pready && !i_pwrite) ? rd_mux_w : 32'h0000_0000;
      o_pslverr <= acc_w & ~o_pready & ~hit_any_w;
    end
  end

  // checks of the storage and driver behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  clear_forces_zero_a: assert property (
    step_w && !clr_n_w |=> store_r == 8'h00)
    else $error("clear at step did not zero storage");

  no_step_stable_a: assert property (
    !step_w |=> $stable(store_r))
    else $error("storage changed without a step");

  load_captures_pins_a: assert property (
    step_w && clr_n_w && mode_w == usr_pkg::USR_LOAD |=> store_r == $past(pins_s))
    else $error("load did not capture pin values");

  shift_right_moves_a: assert property (
    step_w && clr_n_w && mode_w == usr_pkg::USR_SHIFT_RIGHT
    |=> store_r == {$past(store_r[6:0]), $past(rsi_s)})
    else $error("shift right result wrong");

  shift_left_moves_a: assert property (
    step_w && clr_n_w && mode_w == usr_pkg::USR_SHIFT_LEFT
    |=> store_r == {$past(lsi_s), $past(store_r[7:1])})
    else $error("shift left result wrong");

  hold_keeps_bits_a: assert property (
    step_w && clr_n_w && mode_w == usr_pkg::USR_HOLD |=> $stable(store_r))
    else $error("hold mode changed storage");

  enable_high_floats_a: assert property (
    (oea_n_s || oeb_n_s) |=> o_parallel_pins_oe == 8'h00)
    else $error("pins driven with an enable high");

  load_mode_floats_a: assert property (
    mode_w == usr_pkg::USR_LOAD |=> o_parallel_pins_oe == 8'h00)
    else $error("pins driven during load mode");

  drivers_on_a: assert property (
    !oea_n_s && !oeb_n_s && mode_w != usr_pkg::USR_LOAD && !ctrl_r[usr_pkg::CTRL_HIZ]
    |=> o_parallel_pins_oe == 8'hff)
    else $error("drivers not enabled when allowed");

  // main scenarios seen
  load_seen_c: cover property (step_w && clr_n_w && mode_w == usr_pkg::USR_LOAD);
  shr_seen_c: cover property (step_w && clr_n_w && mode_w == usr_pkg::USR_SHIFT_RIGHT);
  shl_seen_c: cover property (step_w && clr_n_w && mode_w == usr_pkg::USR_SHIFT_LEFT);
  clear_seen_c: cover property (step_w && !clr_n_w);
  sw_step_seen_c: cover property (sw_step_w);

endmodule : usr_shift_reg

`default_nettype wire

//--- testbench/usr_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// far side: a bus agent that puts load data on the pins while both selects are high
module usr_bus_model (
  // clock
  input wire logic i_clk,
  // select pins as the agent sees them
  input wire logic i_sel_lo,
  input wire logic i_sel_hi,
  // agent data and the device's pin side
  input wire logic [7:0] i_load_data,
  input wire logic [7:0] i_dev_data,
  input wire logic [7:0] i_dev_oe,
  // resolved wire level
  output logic [7:0] o_pins
);
  logic [7:0] last_r = 8'h00;
  logic drive;
  // the agent drives only in load mode; a released wire flips every cycle so stale data never looks valid
  assign drive = i_sel_lo & i_sel_hi;
  assign o_pins = (i_dev_oe & i_dev_data) | (~i_dev_oe & (drive ? i_load_data : ~last_r));
  // remember the wire level so that a float keeps changing
  always_ff @(posedge i_clk) begin
    last_r <= o_pins;
  end
endmodule : usr_bus_model

`default_nettype wire

//--- testbench/usr_shift_reg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module usr_shift_reg_tb_top;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, ld = 8'h00, pins, dout, doe, exp_q;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, q0, q7, err;
  logic sclk = 1'h0, rsi = 1'h0, lsi = 1'h0, s0 = 1'h0, s1 = 1'h0, clr_n = 1'h1, ea_n = 1'h0, eb_n = 1'h0;
  int bad_count = 0, n_checks = 0, cyc = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  usr_shift_reg u_usr_shift_reg (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_shift_clock(sclk), .i_right_serial_in(rsi), .i_left_serial_in(lsi),
    .i_mode_select_low_bit(s0), .i_mode_select_high_bit(s1), .i_sync_clear_n(clr_n),
    .i_pin_drive_enable_a_n(ea_n), .i_pin_drive_enable_b_n(eb_n), .i_parallel_pins(pins),
    .o_parallel_pins(dout), .o_parallel_pins_oe(doe), .o_bit_zero_serial_out(q0),
    .o_bit_seven_serial_out(q7));

  usr_bus_model u_usr_bus_model (.i_clk(clk), .i_sel_lo(s0), .i_sel_hi(s1), .i_load_data(ld),
    .i_dev_data(dout), .i_dev_oe(doe), .o_pins(pins));

  task results;
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk

  // one apb transfer; waits for pready, the global ceiling cuts a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  // one pin-clock step; margins exceed the synchroniser setup and hold needs
  task automatic step(input logic [1:0] m, input logic r, input logic l, input logic c_n);
    {s1, s0} <= m;
    rsi <= r;
    lsi <= l;
    clr_n <= c_n;
    repeat (6) @(posedge clk);
    sclk <= 1'h1;
    repeat (4) @(posedge clk);
    sclk <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : step

  task t_reset;
    chk(32'(dout), 32'h0);
    chk(32'(doe), 32'h0);
    chk(32'({q7, q0}), 32'h0);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    apb(1'h0, usr_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h400);
  endtask : t_reset

  task t_load;
    ld <= 8'ha5;
    step(2'h3, 1'h0, 1'h0, 1'h1);
    exp_q = 8'ha5;
    chk(32'(doe), 32'h0);
    chk(32'(dout), 32'(exp_q));
  endtask : t_load

  task t_shift;
    step(2'h1, 1'h1, 1'h0, 1'h1);
    exp_q = {exp_q[6:0], 1'h1};
    chk(32'(dout), 32'(exp_q));
    chk(32'({q7, q0}), 32'({exp_q[7], exp_q[0]}));
    chk(32'(doe), 32'hff);
    chk(32'(pins), 32'(exp_q));
    step(2'h2, 1'h0, 1'h1, 1'h1);
    exp_q = {1'h1, exp_q[7:1]};
    chk(32'(dout), 32'(exp_q));
  endtask : t_shift

  // load mode with new pin data but no pin clock edge must leave storage alone
  task t_hold;
    ld <= 8'h3c;
    {s1, s0} <= 2'h3;
    repeat (8) @(posedge clk);
    chk(32'(dout), 32'(exp_q));
    step(2'h0, 1'h1, 1'h1, 1'h1);
    chk(32'(dout), 32'(exp_q));
  endtask : t_hold

  task t_oe;
    ea_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk(32'(doe), 32'h0);
    step(2'h1, 1'h0, 1'h0, 1'h1);
    exp_q = {exp_q[6:0], 1'h0};
    chk(32'(dout), 32'(exp_q));
    ea_n <= 1'h0;
    eb_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk(32'(doe), 32'h0);
    eb_n <= 1'h0;
    repeat (4) @(posedge clk);
    chk(32'(doe), 32'hff);
  endtask : t_oe

  task t_clear;
    step(2'h1, 1'h1, 1'h1, 1'h0);
    exp_q = 8'h00;
    chk(32'(dout), 32'(exp_q));
    // release the clear pin, else every later software step would clear as well
    clr_n <= 1'h1;
    repeat (4) @(posedge clk);
  endtask : t_clear

  // software override: selects and clear from the control word, step by register
  task t_apb;
    apb(1'h1, usr_pkg::OFS_CTRL, 32'hffff_ffe3);
    apb(1'h0, usr_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'h1, usr_pkg::OFS_STEP, 32'h1);
    exp_q = {exp_q[6:0], 1'h1};
    apb(1'h0, usr_pkg::OFS_STATUS, 32'h0);
    chk(rd, {19'h0, exp_q[7], exp_q[0], 1'h1, 2'h1, exp_q});
    apb(1'h1, usr_pkg::OFS_CTRL, 32'h9);
    apb(1'h1, usr_pkg::OFS_STEP, 32'h1);
    chk(32'(dout), 32'h0);
    apb(1'h0, usr_pkg::OFS_STEP, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h0c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, usr_pkg::OFS_CTRL, 32'h0);
  endtask : t_apb

  // ceiling far above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    t_reset();
    t_load();
    t_shift();
    t_hold();
    t_oe();
    t_clear();
    t_apb();
    results();
  end
endmodule : usr_shift_reg_tb_top

`default_nettype wire
